// ==== hw/spr_register_space.sv ====
// Internal register space: scratchpad, banks, bit area and stack.
`include "spr_defs.svh"
module spr_register_space
  import spr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire spr_op_e op,
  input wire logic wr_en,
  input wire logic indirect,
  input wire spr_byte_t addr,
  input wire logic [2:0] wreg_sel,
  input wire spr_byte_t wr_data,
  input wire logic bit_wr_data,
  input wire logic [1:0] bank_sel,
  output spr_byte_t rd_data,
  output logic rd_bit,
  output logic sfr_access,
  output spr_byte_t sfr_addr,
  output spr_byte_t stack_top_pointer
);
  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  // No reset on the array: contents survive rst and power loss.
  // The scratchpad sits in its own space, apart from program and data
  // memory, so no external memory path ever reaches it.
  spr_byte_t scratch_mem [0:`SPR_SCRATCH_DEPTH-1];

  // ---------------------------------------------------------------
  // Internal signals
  // ---------------------------------------------------------------
  spr_byte_t sp_value;
  spr_byte_t sp_plus_one;
  spr_byte_t cur_byte;
  spr_byte_t merged_byte;
  logic [7:0] bit_mask;
  logic [6:0] eff_addr;
  logic [2:0] bit_pos;
  logic eff_hit;
  logic is_push;
  logic is_pop;
  logic direct_ctrl;
  logic byte_wr;
  logic bit_wr;
  logic sp_load;

  // ---------------------------------------------------------------
  // Decoding helpers
  // ---------------------------------------------------------------
  // Control space is the upper half of the register address range.
  function automatic logic is_ctrl(input spr_byte_t a);
    is_ctrl = (a >= `SPR_CTRL_BASE);
  endfunction

  function automatic logic [6:0] bank_addr(input logic [1:0] bank,
                                           input logic [2:0] reg_idx);
    bank_addr = {2'b00, bank, reg_idx};
  endfunction

  // A control-space access counts only when it is direct. Bit
  // instructions always name their bit directly, so the indirect
  // flag is ignored for them.
  function automatic logic ctrl_direct(input spr_op_e o,
                                       input logic ind,
                                       input spr_byte_t a);
    ctrl_direct = is_ctrl(a) &&
                  (((o == SPR_OP_BYTE) && !ind) || (o == SPR_OP_BIT));
  endfunction

  // ---------------------------------------------------------------
  // Operation decode
  // ---------------------------------------------------------------
  // Only one operation arrives per cycle, so the strobes below are
  // mutually exclusive by construction.
  assign is_push = (op == SPR_OP_PUSH);
  assign is_pop = (op == SPR_OP_POP);
  assign direct_ctrl = ctrl_direct(op, indirect, addr);

  // ---------------------------------------------------------------
  // Effective scratchpad address
  // ---------------------------------------------------------------
  // Bit addresses below 80h index the 16-byte area at 20h. The same
  // address value means a byte or a bit depending on the operation.
  always_comb begin
    eff_addr = addr[6:0];
    eff_hit = 1'b0;
    bit_pos = 3'h0;
    case (op)
      SPR_OP_BYTE: begin
        eff_addr = addr[6:0];
        // Indirect access never reaches control space.
        eff_hit = !is_ctrl(addr);
      end
      SPR_OP_BIT: begin
        eff_addr = `SPR_BIT_AREA_BASE + {3'b000, addr[6:3]};
        bit_pos = addr[2:0];
        eff_hit = !is_ctrl(addr);
      end
      SPR_OP_WREG: begin
        eff_addr = bank_addr(bank_sel, wreg_sel);
        eff_hit = 1'b1;
      end
      SPR_OP_PUSH: begin
        eff_addr = sp_plus_one[6:0];
        eff_hit = 1'b1;
      end
      SPR_OP_POP: begin
        eff_addr = sp_value[6:0];
        eff_hit = 1'b1;
      end
      default: begin
        eff_hit = 1'b0;
      end
    endcase
  end

  // ---------------------------------------------------------------
  // Stack pointer
  // ---------------------------------------------------------------
  // Only a direct byte write to the pointer's address loads it; an
  // indirect write into control space is dropped.
  assign sp_load = wr_en && direct_ctrl && (op == SPR_OP_BYTE) &&
                   (addr == `SPR_STACK_PTR_ADDR);

  spr_stack_ptr u_sp (
    .ref_clk(ref_clk),
    .rst(rst),
    .push(is_push),
    .pop(is_pop),
    .load(sp_load),
    .load_data(wr_data),
    .sp_value(sp_value),
    .sp_plus_one(sp_plus_one)
  );

  assign stack_top_pointer = sp_value;

  // ---------------------------------------------------------------
  // Bit lanes
  // ---------------------------------------------------------------
  // One mask bit per lane selects the bit that a bit operation
  // touches, for the read as well as for the merge on write.
  genvar lane;
  generate
    for (lane = 0; lane < 8; lane++) begin : g_lane
      assign bit_mask[lane] = (bit_pos == 3'(lane));
    end
  endgenerate

  assign cur_byte = scratch_mem[eff_addr];

  // A bit write is a read-modify-write of its byte, so the seven
  // neighbouring flags keep their values.
  always_comb begin
    merged_byte = wr_data;
    if (bit_wr) begin
      merged_byte = (cur_byte & ~bit_mask) |
                    ({8{bit_wr_data}} & bit_mask);
    end
  end

  // ---------------------------------------------------------------
  // Scratchpad writes
  // ---------------------------------------------------------------
  // Push stores regardless of wr_en: the pointer and the stored byte
  // move together on the same edge.
  assign byte_wr = eff_hit && ((op == SPR_OP_PUSH) ||
                   (wr_en && ((op == SPR_OP_BYTE) || (op == SPR_OP_WREG))));
  assign bit_wr = wr_en && eff_hit && (op == SPR_OP_BIT);

  always_ff @(posedge ref_clk) begin
    if (byte_wr || bit_wr) begin
      scratch_mem[eff_addr] <= merged_byte;
    end
  end

  // ---------------------------------------------------------------
  // Read path and control-space routing
  // ---------------------------------------------------------------
  // Direct control accesses go out to the peripheral registers; the
  // pointer alone is answered here.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sfr_access <= 1'b0;
    end else begin
      sfr_access <= direct_ctrl;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sfr_addr <= 8'h00;
    end else begin
      sfr_addr <= addr;
    end
  end

  // The bit answer is only meaningful after a bit operation.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_bit <= 1'b0;
    end else begin
      rd_bit <= eff_hit ? |(cur_byte & bit_mask) : 1'b0;
    end
  end

  // Indirect reads of control space return a fixed fill value, so
  // software that breaks the direct-only rule sees no stale data.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_data <= 8'h00;
    end else begin
      if (eff_hit) begin
        rd_data <= cur_byte;
      end else if ((op == SPR_OP_BYTE) && indirect) begin
        rd_data <= `SPR_INDIRECT_FILL;
      end else if ((op == SPR_OP_BYTE) &&
                   (addr == `SPR_STACK_PTR_ADDR)) begin
        rd_data <= sp_value;
      end else begin
        rd_data <= 8'h00;
      end
    end
  end
endmodule

// ==== hw/spr_stack_ptr.sv ====
// Stack pointer register with push and pop arithmetic.
`include "spr_defs.svh"
module spr_stack_ptr
  import spr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic push,
  input wire logic pop,
  input wire logic load,
  input wire spr_byte_t load_data,
  output spr_byte_t sp_value,
  output spr_byte_t sp_plus_one
);
  spr_byte_t stack_top_pointer_reg;
  spr_byte_t stack_top_pointer_next;

  // Eight-bit sum drops the carry, so the pointer wraps without a flag.
  assign sp_plus_one = stack_top_pointer_reg + 8'h01;
  assign sp_value = stack_top_pointer_reg;

  always_comb begin
    stack_top_pointer_next = stack_top_pointer_reg;
    if (push) begin
      stack_top_pointer_next = sp_plus_one;
    end else if (pop) begin
      stack_top_pointer_next = stack_top_pointer_reg - 8'h01;
    end else if (load) begin
      stack_top_pointer_next = load_data;
    end
  end

  // The pointer is retained register state; only rst restores it.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stack_top_pointer_reg <= `SPR_STACK_PTR_RESET;
    end else begin
      stack_top_pointer_reg <= stack_top_pointer_next;
    end
  end
endmodule

// ==== shared/spr_defs.svh ====
// Constants for the scratchpad and stack register space.
// Overview of operation
// - 128 read/write scratchpad bytes at 00h-7Fh.
// - Lowest 32 bytes form four eight-byte banks.
// - Control registers occupy addresses 80h through FFh.
// - Control registers reached by direct addressing only.
// - Sixteen bytes give 128 bit-addressable locations.
// - Instruction type selects bit or byte meaning.
// - Stack pointer at 81h resets to 07h.
// - Push and call increment the stack pointer.
// - Stack data lives in the scratchpad area.
// - Scratchpad reached only by internal-register instructions.
// - Scratchpad and pointer keep contents without supply.
// - Eight-bit pointer, pre-increment push, post-decrement pop.
// - Bank select maps base 00h/08h/10h/18h.
`ifndef SPR_DEFS_SVH
`define SPR_DEFS_SVH
`define SPR_SCRATCH_DEPTH 128
`define SPR_CTRL_BASE 8'h80
`define SPR_STACK_PTR_ADDR 8'h81
`define SPR_STACK_PTR_RESET 8'h07
`define SPR_BIT_AREA_BASE 7'h20
`define SPR_BIT_SFR_BASE 8'h80
`define SPR_INDIRECT_FILL 8'h00
`endif

// ==== shared/spr_pkg.sv ====
// Types shared by the scratchpad register space.
package spr_pkg;
  typedef enum logic [2:0] {
    SPR_OP_NONE,
    SPR_OP_BYTE,
    SPR_OP_BIT,
    SPR_OP_WREG,
    SPR_OP_PUSH,
    SPR_OP_POP
  } spr_op_e;
  typedef logic [7:0] spr_byte_t;
endpackage

// ==== verif/scratchpad_and_stack_space_test.sv ====
// Self-checking bench for the scratchpad and stack register space.
module scratchpad_and_stack_space_test
  import spr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk = 0, rst = 1, chk, wr_en, indirect, bit_wr_data, rd_bit;
  logic sfr_access;
  logic [2:0] wreg_sel;
  logic [1:0] bank_sel;
  spr_op_e op;
  spr_byte_t addr, wr_data, rd_data, sfr_addr, stack_top_pointer, a, d;
  logic [8:0] exp_q[$], e;
  int err_total = 0, checks = 0;
  always #50 ref_clk = ~ref_clk;
  spr_register_space dut (.*);
  spr_cpu_model cpu (.*);
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic rd(spr_op_e o, logic i, spr_byte_t a, logic [8:0] x);
    exp_q.push_back(x);
    cpu.go(o, 0, i, a, 8'h00, 0, 0, 0, 1);
  endtask
  task automatic wr(spr_op_e o, logic i, spr_byte_t a, spr_byte_t x);
    cpu.go(o, 1, i, a, x, x[0], 0, 0, 0);
  endtask
  task automatic rs;
    cpu.go(SPR_OP_NONE, 0, 0, 0, 0, 0, 0, 0, 0);
    rst = 1;
    repeat (4) @(posedge ref_clk);
    #1 rst = 0;
  endtask
  task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask
  always @(posedge ref_clk) if (chk === 1'b1) begin
    #2 e = exp_q.pop_front();
    if (e[8]) check("rd_bit", {7'h00, rd_bit}, e[7:0]);
    else check("rd_data", rd_data, e[7:0]);
  end
  initial begin
    repeat (3000) @(posedge ref_clk);
    err_total++;
    report_and_stop();
  end
  initial begin
    void'($urandom(56138));
    rs();
    rd(SPR_OP_BYTE, 0, 8'h81, 9'h007);
    for (int n = 0; n < 8; n++) begin
      a = 8'($urandom % 128);
      d = 8'($urandom);
      wr(SPR_OP_BYTE, 0, a, d);
      rd(SPR_OP_BYTE, 0, a, {1'b0, d});
    end
    for (int k = 0; k < 4; k++) begin
      cpu.go(SPR_OP_WREG, 1, 0, 0, 8'h40 + 8'(k), 0, 3'(k), 2'(k), 0);
      rd(SPR_OP_BYTE, 0, 8'(k * 9), {1'b0, 8'h40 + 8'(k)});
    end
    wr(SPR_OP_BYTE, 0, 8'h2f, 8'h00);
    wr(SPR_OP_BYTE, 0, 8'h7d, 8'h5a);
    wr(SPR_OP_BIT, 0, 8'h7d, 8'h01);
    rd(SPR_OP_BYTE, 0, 8'h2f, 9'h020);
    rd(SPR_OP_BIT, 0, 8'h7d, 9'h101);
    rd(SPR_OP_BYTE, 0, 8'h7d, 9'h05a);
    wr(SPR_OP_PUSH, 0, 0, 8'haa);
    wr(SPR_OP_PUSH, 0, 0, 8'h55);
    rd(SPR_OP_BYTE, 0, 8'h81, 9'h009);
    rd(SPR_OP_BYTE, 0, 8'h08, 9'h0aa);
    rd(SPR_OP_POP, 0, 0, 9'h055);
    rd(SPR_OP_POP, 0, 0, 9'h0aa);
    wr(SPR_OP_BYTE, 0, 8'h81, 8'h00);
    rd(SPR_OP_POP, 0, 0, 9'h040);
    rd(SPR_OP_BYTE, 0, 8'h81, 9'h0ff);
    wr(SPR_OP_PUSH, 0, 0, 8'h77);
    rd(SPR_OP_BYTE, 0, 8'h00, 9'h077);
    rd(SPR_OP_BYTE, 1, 8'h81, 9'h000);
    wr(SPR_OP_BYTE, 1, 8'h81, 8'h33);
    rd(SPR_OP_BYTE, 0, 8'h81, 9'h000);
    rd(SPR_OP_BYTE, 0, 8'h90, 9'h000);
    rs();
    rd(SPR_OP_BYTE, 0, 8'h81, 9'h007);
    rd(SPR_OP_BYTE, 0, 8'h2f, 9'h020);
    cpu.go(SPR_OP_NONE, 0, 0, 0, 0, 0, 0, 0, 0);
    repeat (2) @(posedge ref_clk);
    report_and_stop();
  end
endmodule

// ==== verif/spr_cpu_model.sv ====
// Instruction-side model that issues register space requests.
module spr_cpu_model
  import spr_pkg::*;
(
  input wire logic ref_clk,
  output spr_op_e op,
  output logic wr_en,
  output logic indirect,
  output spr_byte_t addr,
  output spr_byte_t wr_data,
  output logic bit_wr_data,
  output logic [2:0] wreg_sel,
  output logic [1:0] bank_sel,
  output logic chk
);
  initial begin
    op = SPR_OP_NONE;
    {wr_en, indirect, addr, wr_data, bit_wr_data} = '0;
    {wreg_sel, bank_sel, chk} = '0;
  end
  // Random stall cycles; idle lines flip so stale values cannot pass.
  task automatic go(spr_op_e o, logic w, i, spr_byte_t a, d, logic b,
                    logic [2:0] s, logic [1:0] k, logic c);
    @(posedge ref_clk) #1;
    if ($urandom % 4 == 0) begin
      {op, chk, addr, wr_data} = {SPR_OP_NONE, 1'b0, ~addr, ~wr_data};
      @(posedge ref_clk) #1;
    end
    {op, wr_en, indirect, addr, wr_data} = {o, w, i, a, d};
    {bit_wr_data, wreg_sel, bank_sel, chk} = {b, s, k, c};
  endtask
endmodule

// ==== verif/spr_monitor.sv ====
// Port checker for the register space, bound to its top module.
module spr_monitor
  import spr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire spr_op_e op,
  input wire logic wr_en,
  input wire logic indirect,
  input wire spr_byte_t addr,
  input wire spr_byte_t rd_data,
  input wire logic sfr_access,
  input wire spr_byte_t sfr_addr,
  input wire spr_byte_t stack_top_pointer
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire logic rd = op == SPR_OP_BYTE && !wr_en;
  wire logic dir = (op == SPR_OP_BIT || op == SPR_OP_BYTE && !indirect)
    && addr[7];
  wire spr_byte_t sp = stack_top_pointer;
  push_step_a: assert property (op == SPR_OP_PUSH |=>
    sp == $past(sp) + 8'h01) else $error("push step");
  pop_step_a: assert property (op == SPR_OP_POP |=>
    sp == $past(sp) - 8'h01) else $error("pop step");
  ptr_reset_a: assert property (disable iff (1'b0) rst |=>
    sp == 8'h07) else $error("pointer reset");
  ptr_hold_a: assert property (
    op inside {SPR_OP_NONE, SPR_OP_WREG} |=> $stable(sp)) else $error("hold");
  sfr_flag_a: assert property (
    dir |=> sfr_access) else $error("flag missing");
  sfr_quiet_a: assert property (
    !dir |=> !sfr_access) else $error("flag spurious");
  ind_fill_a: assert property (rd && indirect && addr[7] |=>
    rd_data == 8'h00 && !sfr_access) else $error("indirect fill");
  ptr_read_a: assert property (rd && !indirect && addr == 8'h81 |=>
    rd_data == $past(sp)) else $error("pointer read");
  sfr_addr_a: assert property (1'b1 |=>
    sfr_addr == $past(addr)) else $error("control address copy");
  cover property (op == SPR_OP_PUSH ##1 op == SPR_OP_PUSH);
  cover property (op == SPR_OP_POP && sp == 8'h00);
  cover property (rd && indirect && addr[7]);
endmodule
bind spr_register_space spr_monitor mon (.*);
